/* File: sacr_core.sv */
// SAR converter sequencing, code capture and serial readout
// Functional notes
// RULE_01: Alternate between acquisition and conversion phases.
// RULE_02: Falling convert_start_n ends acquisition and starts a conversion.
// RULE_03: Each shift clock pulse advances one approximation step of the DAC.
// RULE_04: Completed conversion yields a 16-bit code queued for serial output.
// RULE_05: Codes are two's complement signed values.
// RULE_06: Bits shifted during a conversion belong to the preceding conversion.
// RULE_07: Full scale of twice reference maps onto 2^16 equal code levels.
// RULE_08: Up to 5 Msps throughput with one conversion of latency.
// RULE_09: Out-of-span codes are still valid; host clamps them.
// RULE_10: Result leaves MSB first, one bit per falling shift clock edge.
// RULE_11: While convert_start_n is high the device stays sampling.
// RULE_12: Host discards the first result read after an idle period.
`timescale 1ns/10ps
`default_nettype none
`include "sacr_regs.svh"
module sacr_core (
    // System clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     arst_n_i,
    // Link pins, shift clock domain
    input  wire logic                     sck_i,
    input  wire logic                     convert_start_n_i,
    output logic                          sdo_o,
    // Comparator decision and DAC trial weights
    input  wire logic                     comp_hi_i,
    output logic [`SACR_CODE_W-1:0]       cap_weight_dac_o,
    output logic                          sampling_o,
    // Captured code stream, system clock domain
    output logic                          code_valid_o,
    input  wire logic                     code_ready_i,
    output sacr_pkg::sacr_word_s          code_o
);
    // Link-side state, sck domain
    sacr_pkg::sacr_phase_e          phase_r;
    logic [`SACR_CODE_W-1:0]        sar_r;
    logic [`SACR_CODE_W-1:0]        trial_r;
    logic [`SACR_CODE_W-1:0]        result_r;
    logic [`SACR_CODE_W-1:0]        shift_r;
    logic [`SACR_CNT_W-1:0]         step_r;
    logic                           start_q1_r;
    logic                           start_q2_r;
    logic                           start_prev_r;
    logic                           first_r;
    logic                           done_tgl_r;
    logic                           sdo_r;
    logic                           result_first_r;
    logic                           start_fall;

    // Convert input is asynchronous to sck: two-stage sync
    always_ff @(posedge sck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_q1_r   <= 1'b1;
            start_q2_r   <= 1'b1;
            start_prev_r <= 1'b1;
        end else begin
            start_q1_r   <= convert_start_n_i;
            start_q2_r   <= start_q1_r;
            start_prev_r <= start_q2_r;
        end
    end
    // RULE_02: high-to-low seen on the synced pin only
    assign start_fall = start_prev_r & ~start_q2_r;

    // Phase machine and successive approximation
    always_ff @(posedge sck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_r        <= sacr_pkg::SACR_ACQ;
            sar_r          <= 16'h0000;
            trial_r        <= 16'h8000;
            step_r         <= 5'h00;
            result_r       <= 16'h0000;
            result_first_r <= 1'b1;
            first_r        <= 1'b1;
            done_tgl_r     <= 1'b0;
        end else begin
            case (phase_r)
                sacr_pkg::SACR_ACQ: begin
                    // RULE_11: hold sampling
                    // RULE_02: falling edge starts conversion
                    if (start_fall) begin
                        phase_r <= sacr_pkg::SACR_CONV;
                        sar_r   <= 16'h0000;
                        trial_r <= 16'h8000;
                        step_r  <= 5'h00;
                    end
                end
                sacr_pkg::SACR_CONV: begin
                    // RULE_03: one step per pulse
                    // RULE_07: binary weights, 2^16 levels
                    if (comp_hi_i) begin
                        sar_r <= sar_r | trial_r;
                    end
                    trial_r <= trial_r >> 1;
                    step_r  <= step_r + 5'h01;
                    if (step_r == `SACR_BITS - 5'h01) begin
                        // RULE_04: code ready; RULE_05: offset to two's complement
                        // RULE_09: no clamping of out-of-span codes
                        result_r       <= (sar_r | (comp_hi_i ? trial_r : 16'h0000)) ^ 16'h8000;
                        result_first_r <= first_r;
                        first_r        <= 1'b0;
                        done_tgl_r     <= ~done_tgl_r;
                        // RULE_01: back to acquisition
                        phase_r        <= sacr_pkg::SACR_ACQ;
                    end
                end
                default: phase_r <= sacr_pkg::SACR_ACQ;
            endcase
        end
    end

    // RULE_10: falling edge shifts MSB first
    // RULE_06: load previous result at conversion start
    always_ff @(negedge sck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_r <= 16'h0000;
            sdo_r   <= 1'b0;
        end else if (phase_r == sacr_pkg::SACR_CONV && step_r == 5'h00) begin
            sdo_r   <= result_r[`SACR_MSB_IDX];
            shift_r <= {result_r[14:0], 1'b0};
        end else begin
            sdo_r   <= shift_r[`SACR_MSB_IDX];
            shift_r <= {shift_r[14:0], 1'b0};
        end
    end

    assign sdo_o            = sdo_r;
    assign cap_weight_dac_o = sar_r | trial_r;
    assign sampling_o       = (phase_r == sacr_pkg::SACR_ACQ);

    // Word crossing into system clock by toggle; result_r stable a full conversion
    logic                     tg_q1_r;
    logic                     tg_q2_r;
    logic                     tg_prev_r;
    logic [1:0]               cnt_r;
    sacr_pkg::sacr_word_s     buf_r [0:1];
    logic                     wr_r;
    logic                     rd_r;
    logic                     push;
    logic                     pop;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tg_q1_r   <= 1'b0;
            tg_q2_r   <= 1'b0;
            tg_prev_r <= 1'b0;
        end else begin
            tg_q1_r   <= done_tgl_r;
            tg_q2_r   <= tg_q1_r;
            tg_prev_r <= tg_q2_r;
        end
    end

    // RULE_08: two-entry buffer absorbs receiver stalls of up to two words at full rate; a third arriving while full is dropped
    assign push = (tg_q2_r ^ tg_prev_r) && (cnt_r != 2'h2);
    assign pop  = code_ready_i && (cnt_r != 2'h0);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r    <= 2'h0;
            wr_r     <= 1'b0;
            rd_r     <= 1'b0;
            buf_r[0] <= '0;
            buf_r[1] <= '0;
        end else begin
            if (push) begin
                buf_r[wr_r] <= '{code: result_r, first: result_first_r};
                wr_r        <= ~wr_r;
            end
            if (pop) begin
                rd_r <= ~rd_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    assign code_valid_o = (cnt_r != 2'h0);
    assign code_o       = buf_r[rd_r];

    // Checks, sck domain
    // RULE_02: taken convert fall
    chk_conv_start: assert property (@(posedge sck_i) disable iff (!arst_n_i) // RULE_02
        (sampling_o && start_fall) |=> (phase_r == sacr_pkg::SACR_CONV))
        else $error("conversion did not start");
    // RULE_11: sampling held
    chk_stay_acq: assert property (@(posedge sck_i) disable iff (!arst_n_i) // RULE_11
        (sampling_o && !start_fall) |=> sampling_o)
        else $error("left sampling without convert");
    // RULE_03: exactly sixteen steps, split to keep repetitions short
    chk_sixteen_steps: assert property (@(posedge sck_i) disable iff (!arst_n_i) // RULE_03
        $rose(phase_r == sacr_pkg::SACR_CONV) |->
            (!sampling_o)[*8] ##1 (!sampling_o)[*8] ##1 sampling_o)
        else $error("conversion length not 16");
    // RULE_01: back to acquisition
    chk_phase_alt: assert property (@(posedge sck_i) disable iff (!arst_n_i) // RULE_01
        $fell(sampling_o) |-> ##[1:16] sampling_o)
        else $error("no return to acquisition");
    // RULE_04: result handed over
    chk_result_tgl: assert property (@(posedge sck_i) disable iff (!arst_n_i) // RULE_04
        $rose(sampling_o) |-> (done_tgl_r != $past(done_tgl_r)))
        else $error("result not delivered");
    // RULE_07: binary weight walk
    chk_trial_walk: assert property (@(posedge sck_i) disable iff (!arst_n_i) // RULE_07
        (!sampling_o && step_r != 5'h00) |-> (trial_r == 16'h8000 >> step_r))
        else $error("trial weight wrong");
    // RULE_10: MSB leads the word
    chk_msb_first: assert property (@(negedge sck_i) disable iff (!arst_n_i) // RULE_10
        (!sampling_o && step_r == 5'h00) |=> (sdo_r == $past(result_r[15])))
        else $error("msb not first");
    // Checks, system clock domain
    // RULE_08: full buffer keeps its words
    chk_buf_full: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_08
        (cnt_r == 2'h2 && !code_ready_i) |=> (cnt_r == 2'h2))
        else $error("buffer lost a word");
    // RULE_08: offered word holds until taken
    chk_code_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_08
        (code_valid_o && !code_ready_i) |=> (code_valid_o && $stable(code_o)))
        else $error("offered word changed before taken");
    // Main scenarios reached
    cov_conv: cover property (@(posedge sck_i) disable iff (!arst_n_i)
        $rose(sampling_o));
    cov_full: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) cnt_r == 2'h2);
    cov_pop: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) pop && push);
    // Word arriving while full is dropped by design
    cov_drop: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (tg_q2_r ^ tg_prev_r) && cnt_r == 2'h2);
endmodule : sacr_core
`default_nettype wire

/* File: sacr_core_tb_top.sv */
// Testbench: host model, stream model and consumer stall
`timescale 1ns/10ps
`default_nettype none
module sacr_core_tb_top;
    logic                 clk_sys_i, arst_n_i, code_ready_i, stall;
    logic                 sck, start_n, sdo, comp_hi, sampling, code_valid;
    logic [15:0]          dac, lfsr, w, prev, s;
    sacr_pkg::sacr_word_s code;
    int                   failures, n_tests, n_words;
    logic [15:0]          exp_q[$];
    logic [15:0]          corners[4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};

    sacr_core sacr_core_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .sck_i(sck),
        .convert_start_n_i(start_n), .sdo_o(sdo), .comp_hi_i(comp_hi),
        .cap_weight_dac_o(dac), .sampling_o(sampling), .code_valid_o(code_valid),
        .code_ready_i(code_ready_i), .code_o(code));
    sacr_host_model sacr_host_model_inst (.sck_o(sck), .convert_start_n_o(start_n),
        .sdo_i(sdo), .dac_i(dac), .comp_hi_o(comp_hi));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    always #50 clk_sys_i = ~clk_sys_i;
    // Random consumer ready, held low while stalling
    always @(posedge clk_sys_i) begin
        lfsr <= lfsr_next(lfsr);
        code_ready_i <= !stall && lfsr[0];
    end
    // Each accepted word against the model queue
    always @(posedge clk_sys_i) begin
        if (arst_n_i === 1'b1 && code_valid === 1'b1 && code_ready_i === 1'b1) begin
            check("code_o", {exp_q.size() ? exp_q[0] : 16'hxxxx, n_words == 0}, code);
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
            n_words++;
        end
    end
    // Watchdog well beyond the expected run
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
    initial begin
        clk_sys_i = 1'b0;
        arst_n_i = 1'b0;
        code_ready_i = 1'b0;
        stall = 1'b0;
        lfsr = 16'hd953;
        prev = 16'h0000;
        // Reset must see link clock edges too
        sacr_host_model_inst.pulse(4);
        repeat (8) @(posedge clk_sys_i);
        check("sampling_o", 17'h00001, {16'h0000, sampling});
        check("code_valid_o", 17'h00000, {16'h0000, code_valid});
        arst_n_i <= 1'b1;
        // Corner codes, then random samples, one conversion latency
        for (int k = 0; k < 14; k++) begin
            s = (k < 4) ? corners[k] : lfsr;
            for (int t = 0; t < 60 && exp_q.size() != 0; t++) @(posedge clk_sys_i);
            sacr_host_model_inst.frame(s, w);
            if (k > 0)
                check("sdo word", {1'b0, prev}, {1'b0, w});
            prev = s ^ 16'h8000;
            exp_q.push_back(prev);
            check("sampling_o", 17'h00001, {16'h0000, sampling});
        end
        for (int t = 0; t < 60 && exp_q.size() != 0; t++) @(posedge clk_sys_i);
        // Stall the consumer: two words kept, the third lost
        @(posedge clk_sys_i) stall <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        for (int k = 0; k < 3; k++) begin
            s = lfsr;
            sacr_host_model_inst.frame(s, w);
            check("sdo word", {1'b0, prev}, {1'b0, w});
            prev = s ^ 16'h8000;
            if (exp_q.size() < 2)
                exp_q.push_back(prev);
            repeat (10) @(posedge clk_sys_i);
        end
        check("code_valid_o", 17'h00001, {16'h0000, code_valid});
        @(posedge clk_sys_i) stall <= 1'b0;
        for (int t = 0; t < 60 && exp_q.size() != 0; t++) @(posedge clk_sys_i);
        repeat (6) @(posedge clk_sys_i);
        check("words taken", 17'd16, n_words[16:0]);
        check("code_valid_o", 17'h00000, {16'h0000, code_valid});
        wrap_up();
    end
endmodule : sacr_core_tb_top
`default_nettype wire

/* File: sacr_host_model.sv */
// Host side model: link clock, convert strobe, comparator, word capture
`timescale 1ns/10ps
`default_nettype none
module sacr_host_model (
    // Link pins
    output logic              sck_o,
    output logic              convert_start_n_o,
    input  wire logic         sdo_i,
    // Analog stand-in
    input  wire logic [15:0]  dac_i,
    output logic              comp_hi_o
);
    logic [15:0] sample_r;
    assign comp_hi_o = (sample_r >= dac_i);
    initial begin
        sck_o = 1'b0;
        convert_start_n_o = 1'b1;
        sample_r = 16'h0000;
    end
    // Link clock pulses, idle low between frames
    task automatic pulse(input int n);
        repeat (n) begin
            #7.5 sck_o = 1'b1;
            #7.5 sck_o = 1'b0;
        end
    endtask : pulse
    // convert, reading the previous word while it converts
    task automatic frame(input logic [15:0] s, output logic [15:0] w);
        sample_r = s;
        pulse(2);
        convert_start_n_o = 1'b0;
        pulse(3);
        for (int i = 15; i >= 0; i--) begin
            #7.5 w[i] = sdo_i;
            sck_o = 1'b1;
            #7.5 sck_o = 1'b0;
        end
        convert_start_n_o = 1'b1;
        pulse(2);
    endtask : frame
endmodule : sacr_host_model
`default_nettype wire

/* File: sacr_pkg.sv */
// Types shared by the SAR convert and readout block
`default_nettype none
package sacr_pkg;
    typedef enum logic [1:0] {
        SACR_ACQ  = 2'b01,
        SACR_CONV = 2'b10
    } sacr_phase_e;
    typedef struct packed {
        logic [15:0] code;
        logic        first;
    } sacr_word_s;
endpackage : sacr_pkg
`default_nettype wire

/* File: sacr_regs.svh */
// Timing counts and field constants for the SAR convert and readout block
`ifndef SACR_REGS_SVH
`define SACR_REGS_SVH
`define SACR_CODE_W      16
`define SACR_CNT_W       5
`define SACR_BITS        5'h10
`define SACR_MSB_IDX     4'hf
`define SACR_CLK_SYS_NS  100
`define SACR_TPUT_MSPS   5
`define SACR_CYC_NS      (1000 / `SACR_TPUT_MSPS)
`define SACR_CYC_CLKS    ((`SACR_CYC_NS + `SACR_CLK_SYS_NS - 1) / `SACR_CLK_SYS_NS)
`endif
